/* File: hdl/pmr_pkg.sv */
package pmr_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_CONTROL   = 12'h000;
	localparam logic [11:0] OFS_DATA_HIGH = 12'h004;
	localparam logic [11:0] OFS_DATA_LOW  = 12'h008;
	localparam logic [11:0] OFS_ADDR_HIGH = 12'h00C;
	localparam logic [11:0] OFS_ADDR_LOW  = 12'h010;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int         WORD_W        = 14;
	localparam int         ADDR_W        = 13;
	localparam int         CTL_START_BIT = 0;
	localparam int         CTL_RSVD_BIT  = 7;
	localparam logic [7:0] CTL_RSVD_VAL  = 8'h80;

	// ----------------------------------------
	// Reset values (undefined in hardware, zero here)
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ----------------------------------------
	// Timing: fetch takes two instruction cycles
	// ----------------------------------------
	localparam int          FETCH_CYCLES = 2;
	localparam logic [1:0]  FETCH_LAST   = 2'(FETCH_CYCLES - 1);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		PMR_IDLE  = 3'b001,
		PMR_FETCH = 3'b010,
		PMR_LOAD  = 3'b100
	} pmr_state_e;

	typedef struct packed {
		logic              req;
		logic [ADDR_W-1:0] addr;
	} pmr_fetch_req_s;

	typedef struct packed {
		logic              valid;
		logic [WORD_W-1:0] word;
	} pmr_fetch_rsp_s;

endpackage

/* File: hdl/pmr_fetch_seq.sv */
`timescale 1ns/1ps
`default_nettype none

module pmr_fetch_seq
	import pmr_pkg::*;
(
	// Clock and reset
	input  wire logic           mclk,
	input  wire logic           nrst,
	// Start and completion
	input  wire logic           start,
	output logic                busy,
	output logic                done,
	// Flash array side
	output var pmr_fetch_req_s  flash_req,
	// Word address from the register pair
	input  wire logic [ADDR_W-1:0] addr
);

	// ----------------------------------------
	// Two-cycle fetch sequencer
	// ----------------------------------------
	pmr_state_e state;
	pmr_state_e next_state;
	logic [1:0] cnt;
	logic [1:0] next_cnt;

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		unique case (state)
			PMR_IDLE: begin
				if (start) begin
					next_state = PMR_FETCH; // [R2]
					next_cnt   = 2'h0;
				end
			end
			PMR_FETCH: begin
				// Count both instruction cycles even if the array answers early
				if (cnt == FETCH_LAST) begin
					next_state = PMR_LOAD; // [R3]
				end else begin
					next_cnt = cnt + 2'h1;
				end
			end
			PMR_LOAD: begin
				next_state = PMR_IDLE;
			end
			default: begin
				next_state = PMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= PMR_IDLE;
			cnt   <= 2'h0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	assign busy           = (state != PMR_IDLE);
	assign done           = (state == PMR_LOAD);
	assign flash_req.req  = (state == PMR_FETCH);
	assign flash_req.addr = addr; // [R1]

endmodule

`default_nettype wire

/* File: hdl/pmr_read_port.sv */
// Functional notes
// [R1] Fetch address is high:low register concatenation
// [R2] Setting start bit launches a fetch
// [R3] Fetch takes two cycles; CPU stalls
// [R4] Software puts no-ops in skipped slots
// [R5] Completed word loads both data registers
// [R6] Code protection never blocks the read
// [R7] Hardware clears start; writing zero ignored
// [R8] Control top bit reserved, reads one
// [R9] Control bits six to one read zero
// [R10] Data high holds word bits 13:8
// [R11] Data low holds word bits 7:0
// [R12] Address high holds bits 12:8
// [R13] Address low read/write, eight bits
// [R14] Start reads one while fetch busy
`timescale 1ns/1ps
`default_nettype none

module pmr_read_port
	import pmr_pkg::*;
(
	// Clock and reset
	input  wire logic           mclk,
	input  wire logic           nrst,
	// APB slave
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [11:0]    paddr,
	input  wire logic [31:0]    pwdata,
	output logic                pready,
	output logic [31:0]         prdata,
	output logic                pslverr,
	// Processor stall for the skipped slots
	output logic                cpu_stall,
	// Flash array side
	output var pmr_fetch_req_s  flash_req,
	input  wire pmr_fetch_rsp_s flash_rsp
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// One register per aligned word, so an exact match is enough
	function automatic logic reg_hit(
		input logic [11:0] addr_in,
		input logic [11:0] slot
	);
		return (addr_in == slot);
	endfunction

	function automatic logic [31:0] byte_word(
		input logic [7:0] value
	);
		return {24'h00_0000, value};
	endfunction

	function automatic logic [5:0] word_high_bits(
		input logic [WORD_W-1:0] word
	);
		return word[13:8];
	endfunction

	function automatic logic [7:0] word_low_bits(
		input logic [WORD_W-1:0] word
	);
		return word[7:0];
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]        addr_low;
	logic [4:0]        addr_high;
	logic [5:0]        data_high;
	logic [7:0]        data_low;
	logic [WORD_W-1:0] held_word;

	// ----------------------------------------
	// Next values and status
	// ----------------------------------------
	logic [7:0]        next_addr_low;
	logic [4:0]        next_addr_high;
	logic [5:0]        next_data_high;
	logic [7:0]        next_data_low;
	logic [WORD_W-1:0] next_held_word;
	logic [31:0]       next_prdata;
	logic              busy;
	logic              done;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire logic access   = psel && penable;
	wire logic wr_en    = access && pwrite;
	// Read data is taken in the setup cycle so it stands at the access edge
	wire logic rd_setup = psel && !penable && !pwrite;
	wire logic hit_ctl  = reg_hit(paddr, OFS_CONTROL);
	wire logic hit_dh   = reg_hit(paddr, OFS_DATA_HIGH);
	wire logic hit_dl   = reg_hit(paddr, OFS_DATA_LOW);
	wire logic hit_ah   = reg_hit(paddr, OFS_ADDR_HIGH);
	wire logic hit_al   = reg_hit(paddr, OFS_ADDR_LOW);
	wire logic mapped   = hit_ctl | hit_dh | hit_dl | hit_ah | hit_al;

	// ----------------------------------------
	// Write strobes
	// ----------------------------------------
	wire logic wr_ctl    = wr_en && hit_ctl;
	wire logic wr_dh     = wr_en && hit_dh;
	wire logic wr_dl     = wr_en && hit_dl;
	wire logic wr_ah     = wr_en && hit_ah;
	wire logic wr_al     = wr_en && hit_al;
	// Data pair is frozen while a fetch is pending
	wire logic data_open = !busy;
	// Only a written one counts; zero cannot cancel a fetch
	wire logic start     = wr_ctl && pwdata[CTL_START_BIT] && !busy; // [R7]
	wire logic capture   = flash_req.req && flash_rsp.valid;

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// Every register answers at once: no wait states
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// ----------------------------------------
	// Fetch sequencer
	// ----------------------------------------
	pmr_fetch_seq u_seq (
		.mclk      (mclk),
		.nrst      (nrst),
		.start     (start),
		.busy      (busy),
		.done      (done),
		.flash_req (flash_req),
		.addr      ({addr_high, addr_low}) // [R1]
	);

	// Processor stalls for the three cycles after the setting write: two fetch cycles plus the load cycle
	assign cpu_stall = busy; // [R3]

	// ----------------------------------------
	// Next-value selection
	// ----------------------------------------
	// No protection gating on the capture path
	assign next_held_word = capture ? flash_rsp.word : held_word; // [R6]
	assign next_addr_low  = wr_al ? pwdata[7:0] : addr_low; // [R13]
	assign next_addr_high = wr_ah ? pwdata[4:0] : addr_high; // [R12]

	// Completion outranks a software write in the same cycle
	wire logic [5:0] sw_data_high = (wr_dh && data_open) ? pwdata[5:0] : data_high;
	wire logic [7:0] sw_data_low  = (wr_dl && data_open) ? pwdata[7:0] : data_low;
	assign next_data_high = done ? word_high_bits(held_word) : sw_data_high; // [R5] [R10]
	assign next_data_low  = done ? word_low_bits(held_word) : sw_data_low; // [R5] [R11]

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire logic [7:0]  ctl_rd = CTL_RSVD_VAL | {7'h00, busy}; // [R8] [R9] [R14]
	wire logic [31:0] rd_ctl = byte_word(ctl_rd);
	wire logic [31:0] rd_dh  = byte_word({2'h0, data_high}); // [R10]
	wire logic [31:0] rd_dl  = byte_word(data_low); // [R11]
	wire logic [31:0] rd_ah  = byte_word({3'h0, addr_high}); // [R12]
	wire logic [31:0] rd_al  = byte_word(addr_low); // [R13]

	// Offsets are distinct, so at most one arm matches; unmapped reads zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		unique case (1'b1)
			hit_ctl: begin
				next_prdata = rd_ctl;
			end
			hit_dh: begin
				next_prdata = rd_dh;
			end
			hit_dl: begin
				next_prdata = rd_dl;
			end
			hit_ah: begin
				next_prdata = rd_ah;
			end
			hit_al: begin
				next_prdata = rd_al;
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			held_word <= '0;
		end else begin
			held_word <= next_held_word;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			addr_low <= RST_BYTE;
		end else begin
			addr_low <= next_addr_low;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			addr_high <= 5'h00;
		end else begin
			addr_high <= next_addr_high;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			data_high <= 6'h00;
		end else begin
			data_high <= next_data_high;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			data_low <= RST_BYTE;
		end else begin
			data_low <= next_data_low;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end
	end

endmodule

`default_nettype wire

/* File: tb/pmr_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmr_flash_model
	import pmr_pkg::*;
(
	// Array side
	input  wire logic           mclk,
	input  wire logic           slow,
	input  wire pmr_fetch_req_s flash_req,
	output var pmr_fetch_rsp_s  flash_rsp
);
	logic        prev_req;
	logic [12:0] a;
	wire         v = flash_req.req & (~slow | prev_req);
	assign a = flash_req.addr;
	always_ff @(posedge mclk) begin
		prev_req <= flash_req.req;
	end
	// Off-cycle word is inverted so a stale capture shows up
	assign flash_rsp = v ? {1'b1, ~a[0], a} : {1'b0, a[0], ~a};
endmodule
`default_nettype wire

/* File: tb/pmr_read_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pmr_read_port_monitor
	import pmr_pkg::*;
(
	// Observed ports
	input wire logic           mclk,
	input wire logic           nrst,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [11:0]    paddr,
	input wire logic [31:0]    pwdata,
	input wire logic           pready,
	input wire logic [31:0]    prdata,
	input wire logic           pslverr,
	input wire logic           cpu_stall,
	input wire pmr_fetch_req_s flash_req,
	input wire pmr_fetch_rsp_s flash_rsp
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire acc = psel & penable & pwrite;
	wire rs  = psel & ~penable & ~pwrite;
	wire go  = acc & (paddr == OFS_CONTROL) & ~cpu_stall;
	wire rq  = flash_req.req;
	chk_fetch_start: assert property (go & pwdata[0] |=> rq)
		else $error("fetch not launched");
	chk_zero_write: assert property (go & ~pwdata[0] |=> ~rq)
		else $error("zero write started fetch");
	chk_fetch_two: assert property ($rose(rq) |-> rq[*2] ##1 ~rq)
		else $error("fetch length wrong");
	chk_stall_span: assert property ($rose(cpu_stall) |-> cpu_stall[*3] ##1 ~cpu_stall)
		else $error("stall length wrong");
	chk_addr_low: assert property (acc & paddr == OFS_ADDR_LOW
		|=> flash_req.addr[7:0] == $past(pwdata[7:0])) else $error("low address");
	chk_addr_high: assert property (acc & paddr == OFS_ADDR_HIGH
		|=> flash_req.addr[12:8] == $past(pwdata[4:0])) else $error("high address");
	chk_ctl_read: assert property (rs & paddr == OFS_CONTROL
		|=> prdata == {31'h40, $past(cpu_stall)}) else $error("control read");
	chk_data_high: assert property (rs & paddr == OFS_DATA_HIGH
		|=> prdata[31:6] == 26'h0) else $error("data high upper bits");
	cover property (go & pwdata[0]);
	cover property ($fell(cpu_stall));
	cover property (rs & paddr == OFS_DATA_LOW);
endmodule
bind pmr_read_port pmr_read_port_monitor mon_u (.mclk(mclk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .cpu_stall(cpu_stall), .flash_req(flash_req),
	.flash_rsp(flash_rsp));
`default_nettype wire

/* File: tb/pmr_read_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pmr_read_port_tb;
	import pmr_pkg::*;
	logic           mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
	logic [11:0]    paddr = '0;
	logic [31:0]    pwdata = '0, prdata, rd, lfsr = 32'h0001_3DB3;
	logic           pready, pslverr, cpu_stall, err_seen;
	logic [12:0]    a;
	logic [13:0]    w;
	pmr_fetch_req_s flash_req;
	pmr_fetch_rsp_s flash_rsp;
	int             err_count = 0, cmp_count = 0;
	always #50 mclk = ~mclk;
	pmr_read_port dut_u (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cpu_stall(cpu_stall), .flash_req(flash_req), .flash_rsp(flash_rsp));
	pmr_flash_model mdl_u (.mclk(mclk), .slow(slow), .flash_req(flash_req), .flash_rsp(flash_rsp));
	function automatic logic [31:0] next_lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [13:0] exp_word(input logic [12:0] x);
		return {~x[0], x};
	endfunction
	task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask
	// Zero wait states today, but the loop keeps the master honest
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b1, OFS_CONTROL, 32'h0);
		apb(1'b0, OFS_CONTROL, 32'h0);
		check("control idle", rd, 32'h80);
		apb(1'b0, 12'h014, 32'h0);
		check("unmapped", {rd[30:0], err_seen}, 32'h1);
		apb(1'b1, OFS_DATA_LOW, 32'hA5);
		apb(1'b0, OFS_DATA_LOW, 32'h0);
		check("data low write", rd, 32'hA5);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			lfsr = next_lfsr(lfsr);
			a = (i == 0) ? 13'h1FFF : lfsr[12:0];
			w = exp_word(a);
			slow <= i[0];
			apb(1'b1, OFS_ADDR_HIGH, {lfsr[26:0], a[12:8]});
			apb(1'b1, OFS_ADDR_LOW, {lfsr[31:8], a[7:0]});
			apb(1'b0, OFS_ADDR_HIGH, 32'h0);
			check("address high", rd, {27'h0, a[12:8]});
			apb(1'b0, OFS_ADDR_LOW, 32'h0);
			check("address low", rd, {24'h0, a[7:0]});
			apb(1'b1, OFS_CONTROL, 32'h1);
			apb(1'b0, OFS_CONTROL, 32'h0);
			check("control busy", rd, 32'h81);
			while (cpu_stall === 1'b1) @(posedge mclk);
			apb(1'b0, OFS_DATA_HIGH, 32'h0);
			check("data high", rd, {26'h0, w[13:8]});
			apb(1'b0, OFS_DATA_LOW, 32'h0);
			check("data low", rd, {24'h0, w[7:0]});
		end
		$display("test fetch done");
		end_of_test();
	end
	initial begin
		#(100 * 2000);
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
